// >>> shared/ifeb_pkg.sv
// Function
// RULE1 - one flag per source, reads one after its request, zero otherwise
// RULE2 - one enable per source, one permits the request, zero blocks it
// RULE3 - unimplemented bits read zero and ignore writes
// RULE4 - implemented flag and enable bits are read/write and reset to zero
// RULE5 - without CAN, CAN event, receive and transmit sources stay disabled
// RULE6 - without audio DAC, left and right DAC sources stay disabled
// RULE7 - flag register 1: comparator 2, I2C master 1, I2C slave 0
// RULE8 - flag register 2: DMA4 14, parallel 13, DMA3 4, CAN 3/2, SPI2 1/0
// RULE9 - flag register 3: RTC 14, DMA5 13, codec event 12, codec error 11
// RULE10 - flags 4: DAC 15/14, CAN tx 6, DMA7 5, DMA6 4, CRC 3, UARTs 2/1
// RULE11 - enable register 0: DMA1 14 down to capture1 at 1; the code also implements external interrupt 0 at bit 0
// RULE12 - request goes to the core only while flag and enable are both set
package ifeb_pkg;
   localparam int NREG = 5;
   localparam int RW = 16;
   localparam int DW = 32;
   localparam int AW = 8;
   localparam logic [RW-1:0] REG_RST = 16'h0000;
   localparam logic [NREG-1:0] STAT_RST = 5'h00;
   // byte address = page * 32 + index * 4
   localparam int IDX_LSB = 2;
   localparam int IDX_MSB = 4;
   localparam int PAGE_LSB = 5;
   localparam int PAGE_MSB = 7;
   localparam logic [2:0] FLAG_PAGE = 3'h0;
   localparam logic [2:0] EN_PAGE = 3'h1;
   localparam logic [2:0] EVT_PAGE = 3'h2;
   localparam logic [2:0] EVT_STAT_IDX = 3'h0;
   localparam logic [2:0] EVT_MASK_IDX = 3'h1;
   localparam logic [2:0] LAST_IDX = 3'h4;
   localparam int EXT_INT0_BIT = 0;
   localparam int CAPTURE1_EN = 1;
   localparam int COMPARE1_EN = 2;
   localparam int TIMER1_EN = 3;
   localparam int DMA_CH0_DONE_EN = 4;
   localparam int CAPTURE2_EN = 5;
   localparam int COMPARE2_EN = 6;
   localparam int TIMER2_EN = 7;
   localparam int TIMER3_EN = 8;
   localparam int SPI1_ERROR_EN = 9;
   localparam int SPI1_EVENT_EN = 10;
   localparam int UART1_RX_EN = 11;
   localparam int UART1_TX_EN = 12;
   localparam int ADC_DONE_EN = 13;
   localparam int DMA_CH1_DONE_EN = 14;
   localparam int I2C_SLAVE_EVENT_FLAG = 0;
   localparam int I2C_MASTER_EVENT_FLAG = 1;
   localparam int COMPARATOR_FLAG = 2;
   localparam int SPI2_ERROR_FLAG = 0;
   localparam int SPI2_EVENT_FLAG = 1;
   localparam int CAN_RX_READY_FLAG = 2;
   localparam int CAN_EVENT_FLAG = 3;
   localparam int DMA_CH3_DONE_FLAG = 4;
   localparam int PARALLEL_PORT_FLAG = 13;
   localparam int DMA_CH4_DONE_FLAG = 14;
   localparam int CODEC_IF_ERROR_FLAG = 11;
   localparam int CODEC_IF_EVENT_FLAG = 12;
   localparam int DMA_CH5_DONE_FLAG = 13;
   localparam int RTC_ALARM_FLAG = 14;
   localparam int UART1_ERROR_FLAG = 1;
   localparam int UART2_ERROR_FLAG = 2;
   localparam int CRC_DONE_FLAG = 3;
   localparam int DMA_CH6_DONE_FLAG = 4;
   localparam int DMA_CH7_DONE_FLAG = 5;
   localparam int CAN_TX_REQUEST_FLAG = 6;
   localparam int DAC_RIGHT_FLAG = 14;
   localparam int DAC_LEFT_FLAG = 15;
   localparam logic [RW-1:0] MASK0 = 16'((1 << DMA_CH1_DONE_EN) | (1 << ADC_DONE_EN) // RULE11
      | (1 << UART1_TX_EN) | (1 << UART1_RX_EN) | (1 << SPI1_EVENT_EN) | (1 << SPI1_ERROR_EN)
      | (1 << TIMER3_EN) | (1 << TIMER2_EN) | (1 << COMPARE2_EN) | (1 << CAPTURE2_EN)
      | (1 << DMA_CH0_DONE_EN) | (1 << TIMER1_EN) | (1 << COMPARE1_EN) | (1 << CAPTURE1_EN)
      | (1 << EXT_INT0_BIT));
   localparam logic [RW-1:0] MASK1 = 16'((1 << COMPARATOR_FLAG) // RULE7
      | (1 << I2C_MASTER_EVENT_FLAG) | (1 << I2C_SLAVE_EVENT_FLAG));
   localparam logic [RW-1:0] MASK2 = 16'((1 << DMA_CH4_DONE_FLAG) | (1 << PARALLEL_PORT_FLAG) // RULE8
      | (1 << DMA_CH3_DONE_FLAG) | (1 << CAN_EVENT_FLAG) | (1 << CAN_RX_READY_FLAG)
      | (1 << SPI2_EVENT_FLAG) | (1 << SPI2_ERROR_FLAG));
   localparam logic [RW-1:0] MASK3 = 16'((1 << RTC_ALARM_FLAG) | (1 << DMA_CH5_DONE_FLAG) // RULE9
      | (1 << CODEC_IF_EVENT_FLAG) | (1 << CODEC_IF_ERROR_FLAG));
   localparam logic [RW-1:0] MASK4 = 16'((1 << DAC_LEFT_FLAG) | (1 << DAC_RIGHT_FLAG) // RULE10
      | (1 << CAN_TX_REQUEST_FLAG) | (1 << DMA_CH7_DONE_FLAG) | (1 << DMA_CH6_DONE_FLAG)
      | (1 << CRC_DONE_FLAG) | (1 << UART2_ERROR_FLAG) | (1 << UART1_ERROR_FLAG));
   localparam logic [NREG-1:0][RW-1:0] IMPL_MASK = {MASK4, MASK3, MASK2, MASK1, MASK0};
   localparam logic [NREG-1:0][RW-1:0] CAN_BITS = {16'((1 << CAN_TX_REQUEST_FLAG)), 16'h0000,
      16'((1 << CAN_EVENT_FLAG) | (1 << CAN_RX_READY_FLAG)), 16'h0000, 16'h0000};
   localparam logic [NREG-1:0][RW-1:0] DAC_BITS = {16'((1 << DAC_LEFT_FLAG) | (1 << DAC_RIGHT_FLAG)),
      16'h0000, 16'h0000, 16'h0000, 16'h0000};
   typedef struct packed {
      logic [NREG-1:0][RW-1:0] w;
   } ifeb_bank_t;
endpackage

// >>> rtl/ifeb_reg16.sv
`timescale 1ns/100ps
module ifeb_reg16
   import ifeb_pkg::*;
#(
   parameter logic [RW-1:0] MASK = 16'hFFFF
) (
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic we_in,
   input wire logic [RW-1:0] wdat_in,
   input wire logic [RW-1:0] wmask_in,
   input wire logic [RW-1:0] set_in,
   output logic [RW-1:0] q_out
);
   logic [RW-1:0] q_reg;
   logic [RW-1:0] q_next;
   wire [RW-1:0] wm = we_in ? wmask_in : REG_RST;

   // hardware set wins over a software clear in the same cycle
   assign q_next = MASK & ((q_reg & ~wm) | (wdat_in & wm) | set_in); // RULE1 RULE3 RULE4
   assign q_out = q_reg;

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         q_reg <= REG_RST; // RULE4
      end else if (ce_in) begin
         q_reg <= q_next;
      end
   end

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);

   set_is_sticky_a: assert property (ce_in && (set_in & MASK) != 0 |=> // RULE1
      (q_reg & $past(set_in & MASK)) == $past(set_in & MASK))
      else $error("set flag not captured");
   unimpl_zero_a: assert property ((q_reg & ~MASK) == 0) // RULE3
      else $error("unimplemented bit set");
   frozen_ce_a: assert property (!ce_in |=> $stable(q_reg))
      else $error("register moved with clock enable low");
endmodule

// >>> rtl/ifeb_top.sv
// Our own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/100ps
module ifeb_top
   import ifeb_pkg::*;
#(
   parameter bit HAS_CAN = 1'b1,
   parameter bit HAS_DAC = 1'b1
) (
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [AW-1:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [DW-1:0] wb_dat_in,
   output logic [DW-1:0] wb_dat_out,
   output logic wb_ack_out,
   input wire ifeb_bank_t src_set_in,
   output ifeb_bank_t req_out,
   output logic irq_out
);
   // enable bits of absent peripherals are not implemented at all
   localparam logic [NREG-1:0][RW-1:0] CAN_OFF = HAS_CAN ? '0 : CAN_BITS;
   localparam logic [NREG-1:0][RW-1:0] DAC_OFF = HAS_DAC ? '0 : DAC_BITS;
   localparam logic [NREG-1:0][RW-1:0] EN_MASK = IMPL_MASK & ~CAN_OFF & ~DAC_OFF; // RULE5 RULE6

   logic ack_reg;
   logic [DW-1:0] dat_reg;
   logic [DW-1:0] rd_word;
   logic [NREG-1:0][RW-1:0] flag_q;
   logic [NREG-1:0][RW-1:0] en_q;
   logic [NREG-1:0][RW-1:0] req_next;
   ifeb_bank_t req_reg;
   logic [NREG-1:0] stat_reg;
   logic [NREG-1:0] stat_next;
   logic [NREG-1:0] mask_reg;
   logic [NREG-1:0] mask_next;
   logic [NREG-1:0] evt;
   logic irq_reg;
   logic irq_next;

   // bus decode
   wire bus_req = wb_cyc_in & wb_stb_in;
   wire [2:0] page = wb_adr_in[PAGE_MSB:PAGE_LSB];
   wire [2:0] idx = wb_adr_in[IDX_MSB:IDX_LSB];
   wire idx_ok = idx <= LAST_IDX;
   wire hit_flag = (page == FLAG_PAGE) && idx_ok;
   wire hit_en = (page == EN_PAGE) && idx_ok;
   wire hit_stat = (page == EVT_PAGE) && (idx == EVT_STAT_IDX);
   wire hit_mask = (page == EVT_PAGE) && (idx == EVT_MASK_IDX);
   wire hit_any = hit_flag | hit_en | hit_stat | hit_mask;
   // a write lands on the edge where the master sees ack
   wire wr_fire = ce_in & bus_req & wb_we_in & ack_reg;
   wire [RW-1:0] wmask = {{8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
   wire [NREG-1:0] wmask_s = wmask[NREG-1:0];
   wire [RW-1:0] wdat = wb_dat_in[RW-1:0];
   wire [NREG-1:0] wdat_s = wb_dat_in[NREG-1:0];
   wire stat_wr = wr_fire & hit_stat;
   wire mask_wr = wr_fire & hit_mask;

   // flag and enable banks
   genvar gi;
   generate
      for (gi = 0; gi < NREG; gi++) begin : g_bank
         ifeb_reg16 #(
            .MASK(IMPL_MASK[gi])
         ) u_flag (
            .mclk_in(mclk_in),
            .rst_in(rst_in),
            .ce_in(ce_in),
            .we_in(wr_fire && hit_flag && (idx == 3'(gi))),
            .wdat_in(wdat),
            .wmask_in(wmask),
            .set_in(src_set_in.w[gi]),
            .q_out(flag_q[gi])
         ); // RULE1 RULE4
         ifeb_reg16 #(
            .MASK(EN_MASK[gi])
         ) u_en (
            .mclk_in(mclk_in),
            .rst_in(rst_in),
            .ce_in(ce_in),
            .we_in(wr_fire && hit_en && (idx == 3'(gi))),
            .wdat_in(wdat),
            .wmask_in(wmask),
            .set_in(REG_RST),
            .q_out(en_q[gi])
         ); // RULE2 RULE4
         assign req_next[gi] = flag_q[gi] & en_q[gi]; // RULE12
         assign evt[gi] = |(req_next[gi] & ~req_reg.w[gi]);
      end
   endgenerate

   // read data; unmapped and unimplemented bits read zero
   assign rd_word = hit_flag ? {16'h0000, flag_q[idx]} : // RULE3
                    hit_en ? {16'h0000, en_q[idx]} :
                    hit_stat ? {27'h0000000, stat_reg} :
                    hit_mask ? {27'h0000000, mask_reg} :
                    32'h00000000;

   // event status: set wins over write-one-to-clear
   assign stat_next = (stat_reg & ~(stat_wr ? (wdat_s & wmask_s) : STAT_RST)) | evt;
   assign mask_next = mask_wr ? ((mask_reg & ~wmask_s) | (wdat_s & wmask_s)) : mask_reg;
   assign irq_next = |(stat_next & mask_next);

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h00000000;
      end else if (ce_in) begin
         ack_reg <= bus_req & ~ack_reg;
         dat_reg <= rd_word;
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         req_reg <= '0;
         stat_reg <= STAT_RST;
         mask_reg <= STAT_RST;
         irq_reg <= 1'b0;
      end else if (ce_in) begin
         req_reg.w <= req_next; // RULE12
         stat_reg <= stat_next;
         mask_reg <= mask_next;
         irq_reg <= irq_next;
      end
   end

   assign wb_ack_out = ack_reg;
   assign wb_dat_out = dat_reg;
   assign req_out = req_reg;
   assign irq_out = irq_reg;

   // checks
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);

   sequence s_req_open;
      bus_req && !ack_reg && ce_in;
   endsequence

   sequence s_acked;
      ack_reg ##1 !ack_reg;
   endsequence

   ack_one_cycle_a: assert property (s_req_open |=> s_acked)
      else $error("ack not a single cycle after request");

   unmapped_zero_a: assert property (ack_reg && bus_req && !wb_we_in && !hit_any // RULE3
      |-> wb_dat_out == 32'h00000000)
      else $error("unmapped read not zero");

   read_upper_zero_a: assert property (ack_reg && bus_req && !wb_we_in && (hit_flag || hit_en) // RULE3
      |-> wb_dat_out[DW-1:RW] == 16'h0000)
      else $error("upper half of read not zero");

   forward_both_a: assert property ($past(ce_in) |-> // RULE12
      req_out.w == ($past(flag_q) & $past(en_q)))
      else $error("request not flag and enable");

   can_disabled_a: assert property ((en_q & CAN_OFF) == '0) // RULE5
      else $error("absent CAN source enabled");

   dac_disabled_a: assert property ((en_q & DAC_OFF) == '0) // RULE6
      else $error("absent DAC source enabled");

   reset_clear_a: assert property ($past(rst_in) |-> // RULE4
      flag_q == '0 && en_q == '0 && !irq_out && !wb_ack_out)
      else $error("state not zero after reset");

   en_write_a: assert property (wr_fire && hit_en && wb_sel_in[1:0] == 2'b11 |=> // RULE2
      en_q[$past(idx)] == ($past(wdat) & EN_MASK[$past(idx)]))
      else $error("enable write not stored");

   flag_write_a: assert property (wr_fire && hit_flag && wb_sel_in[1:0] == 2'b11 |=> // RULE1
      (flag_q[$past(idx)] & ~$past(src_set_in.w[idx])) ==
      ($past(wdat) & IMPL_MASK[$past(idx)] & ~$past(src_set_in.w[idx])))
      else $error("flag write not stored");

   evt_set_wins_a: assert property (ce_in && evt != '0 |=>
      (stat_reg & $past(evt)) == $past(evt))
      else $error("event lost against clear");

   irq_level_a: assert property ($past(ce_in) |->
      irq_out == |($past(stat_next) & $past(mask_next)))
      else $error("interrupt level wrong");
endmodule

// >>> bench/ifeb_src_model.sv
`timescale 1ns/100ps
// peripheral sources: one-cycle set request on the chosen flag bit
module ifeb_src_model
   import ifeb_pkg::*;
(
   input wire logic mclk_in,
   input wire logic fire_in,
   input wire logic [2:0] idx_in,
   input wire logic [3:0] bit_in,
   output ifeb_bank_t set_out
);
   initial set_out = '0;
   always @(posedge mclk_in) begin
      set_out <= '0;
      if (fire_in) begin
         set_out.w[idx_in][bit_in] <= 1'b1;
      end
   end
endmodule

// >>> bench/interrupt_flag_enable_bank_tb.sv
`timescale 1ns/100ps
module interrupt_flag_enable_bank_tb;
   import ifeb_pkg::*;
   logic mclk_in = 1'b0;
   logic rst_in = 1'b1;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [AW-1:0] wb_adr = '0;
   logic [3:0] wb_sel = 4'hF;
   logic [DW-1:0] wb_wdat = '0;
   logic [DW-1:0] rdat_a, rdat_b, rd, rd2;
   logic ack_a, ack_b, irq_a, irq_b;
   logic fire = 1'b0;
   logic ce = 1'b1;
   logic [2:0] fire_idx = 3'h0;
   logic [3:0] fire_bit = 4'h0;
   ifeb_bank_t src_set, req_a, req_b;
   int fails = 0;
   int checked = 0;
   int cycles = 0;
   ifeb_src_model ifeb_src_model_inst (.mclk_in(mclk_in), .fire_in(fire), .idx_in(fire_idx),
      .bit_in(fire_bit), .set_out(src_set));
   ifeb_top ifeb_top_inst (.mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce), .wb_cyc_in(wb_cyc),
      .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(wb_sel), .wb_dat_in(wb_wdat),
      .wb_dat_out(rdat_a), .wb_ack_out(ack_a), .src_set_in(src_set), .req_out(req_a), .irq_out(irq_a));
   // variant without CAN and without audio DAC
   ifeb_top #(.HAS_CAN(1'b0), .HAS_DAC(1'b0)) ifeb_top_inst2 (.mclk_in(mclk_in), .rst_in(rst_in),
      .ce_in(ce), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr),
      .wb_sel_in(wb_sel), .wb_dat_in(wb_wdat), .wb_dat_out(rdat_b), .wb_ack_out(ack_b),
      .src_set_in(src_set), .req_out(req_b), .irq_out(irq_b));
   initial begin
      forever #20 mclk_in = ~mclk_in;
   end
   task automatic tally_and_finish;
      if (fails == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic check32(input string what, input logic [DW-1:0] exp, input logic [DW-1:0] got);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // classic single cycle, held until ack, then one idle cycle
   task automatic bus(input logic we, input logic [AW-1:0] adr, input logic [3:0] sel, input logic [DW-1:0] dat);
      @(posedge mclk_in);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_sel <= sel;
      wb_wdat <= dat;
      do @(posedge mclk_in); while (ack_a !== 1'b1);
      rd = rdat_a;
      rd2 = rdat_b;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge mclk_in);
   endtask
   task automatic check_reset;
      for (int i = 0; i < 5; i++) begin
         bus(1'b0, 8'(4 * i), 4'hF, '0);
         check32("flag after reset", '0, rd);
         bus(1'b0, 8'(32 + 4 * i), 4'hF, '0);
         check32("enable after reset", '0, rd);
      end
   endtask
   task automatic check_rw;
      for (int i = 0; i < 5; i++) begin
         bus(1'b1, 8'(4 * i), 4'hF, 32'hFFFFFFFF);
         bus(1'b1, 8'(32 + 4 * i), 4'hF, 32'hFFFFFFFF);
         bus(1'b0, 8'(4 * i), 4'hF, '0);
         check32("flag ones", {16'h0000, IMPL_MASK[i]}, rd);
         check32("variant flag ones", {16'h0000, IMPL_MASK[i]}, rd2);
         bus(1'b0, 8'(32 + 4 * i), 4'hF, '0);
         check32("enable ones", {16'h0000, IMPL_MASK[i]}, rd);
         check32("variant enable", {16'h0000, IMPL_MASK[i] & ~CAN_BITS[i] & ~DAC_BITS[i]}, rd2);
         bus(1'b1, 8'(4 * i), 4'hF, '0);
         bus(1'b1, 8'(32 + 4 * i), 4'hF, '0);
         bus(1'b0, 8'(4 * i), 4'hF, '0);
         check32("flag zero", '0, rd);
         bus(1'b0, 8'(32 + 4 * i), 4'hF, '0);
         check32("enable zero", '0, rd);
      end
      bus(1'b1, 8'h14, 4'hF, 32'hFFFFFFFF);
      bus(1'b0, 8'h14, 4'hF, '0);
      check32("unmapped read", '0, rd);
      bus(1'b1, 8'h00, 4'h1, 32'hFFFFFFFF);
      bus(1'b0, 8'h00, 4'hF, '0);
      check32("low lane write", {16'h0000, IMPL_MASK[0] & 16'h00FF}, rd);
      bus(1'b1, 8'h00, 4'hF, '0);
   endtask
   task automatic check_src;
      int ri[3] = '{0, 2, 4};
      int bi[3] = '{TIMER1_EN, CAN_EVENT_FLAG, DAC_LEFT_FLAG};
      bus(1'b1, 8'h40, 4'hF, 32'h0000001F);
      bus(1'b1, 8'h44, 4'hF, 32'h00000001);
      for (int k = 0; k < 3; k++) begin
         @(posedge mclk_in);
         fire_idx <= 3'(ri[k]);
         fire_bit <= 4'(bi[k]);
         fire <= 1'b1;
         @(posedge mclk_in);
         fire <= 1'b0;
         repeat (3) @(posedge mclk_in);
         bus(1'b0, 8'(4 * ri[k]), 4'hF, '0);
         check32("source flag", 32'(1 << bi[k]), rd);
         check32("request while disabled", '0, {16'h0000, req_a.w[ri[k]]});
         bus(1'b1, 8'(32 + 4 * ri[k]), 4'hF, 32'(1 << bi[k]));
         repeat (2) @(posedge mclk_in);
         check32("request enabled", 32'(1 << bi[k]), {16'h0000, req_a.w[ri[k]]});
         check32("variant request", {16'h0000, 16'(1 << bi[k]) & ~CAN_BITS[ri[k]] & ~DAC_BITS[ri[k]]},
            {16'h0000, req_b.w[ri[k]]});
         if (k == 0) begin
            check32("irq raised", 32'h1, {31'h0, irq_a});
            check32("variant irq raised", 32'h1, {31'h0, irq_b});
            bus(1'b0, 8'h40, 4'hF, '0);
            check32("event status", 32'h1, rd);
            bus(1'b0, 8'h44, 4'hF, '0);
            check32("event mask", 32'h1, rd);
            bus(1'b1, 8'h40, 4'hF, 32'h00000001);
            repeat (2) @(posedge mclk_in);
            check32("irq cleared", '0, {31'h0, irq_a});
         end
         bus(1'b1, 8'(4 * ri[k]), 4'hF, '0);
         repeat (2) @(posedge mclk_in);
         check32("request after clear", '0, {16'h0000, req_a.w[ri[k]]});
         bus(1'b1, 8'(32 + 4 * ri[k]), 4'hF, '0);
      end
   endtask
   // source pulse while clock enable is low must be ignored
   task automatic check_ce;
      @(posedge mclk_in);
      ce <= 1'b0;
      fire_idx <= 3'h3;
      fire_bit <= 4'(RTC_ALARM_FLAG);
      fire <= 1'b1;
      @(posedge mclk_in);
      fire <= 1'b0;
      repeat (2) @(posedge mclk_in);
      ce <= 1'b1;
      bus(1'b0, 8'h0C, 4'hF, '0);
      check32("flag with clock enable low", '0, rd);
   endtask
   // reset in mid-run with flags, enables and irq set
   task automatic check_mid_reset;
      bus(1'b1, 8'h44, 4'hF, 32'h00000001);
      bus(1'b1, 8'h00, 4'hF, 32'h0000FFFF);
      bus(1'b1, 8'h20, 4'hF, 32'h0000FFFF);
      repeat (2) @(posedge mclk_in);
      check32("irq before reset", 32'h1, {31'h0, irq_a});
      rst_in <= 1'b1;
      repeat (2) @(posedge mclk_in);
      rst_in <= 1'b0;
      check32("request in reset", '0, {16'h0000, req_a.w[0]});
      check32("irq in reset", '0, {31'h0, irq_a});
      check_reset;
   endtask
   always @(posedge mclk_in) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails++;
         tally_and_finish;
      end
   end
   initial begin
      repeat (10) @(posedge mclk_in);
      rst_in <= 1'b0;
      check_reset;
      check_rw;
      check_src;
      check_ce;
      check_mid_reset;
      tally_and_finish;
   end
endmodule
